//--- qwsl_pkg.sv
// Constants and carrier types for the quad wiper serial loader.
// Assumes a core clock of 40 MHz and a free-standing serial link clock.
package qwsl_pkg;

	localparam int ADDR_BITS = 2;
	localparam int CODE_BITS = 8;
	localparam int WORD_BITS = ADDR_BITS + CODE_BITS;
	localparam int CHANNELS = 4;
	localparam int FIFO_DEPTH = 8;
	localparam int SYNC_STAGES = 2;

	localparam logic [CODE_BITS-1:0] CODE_MIDSCALE = 8'h80;
	localparam logic [CODE_BITS-1:0] CODE_B_END = 8'h00;
	localparam logic [CODE_BITS-1:0] CODE_A_END = 8'hff;

	localparam int SYNC_CS = 0;
	localparam int SYNC_PRESET = 1;
	localparam int SYNC_PDOWN = 2;
	localparam int SYNC_SDO = 3;
	localparam int SYNC_WIDTH = 4;

	typedef struct packed {
		logic [ADDR_BITS-1:0] addr;
		logic [CODE_BITS-1:0] code;
	} qwsl_word_t;

	typedef logic [CODE_BITS-1:0] qwsl_code_t;

endpackage

//--- qwsl_top.sv
// Serial loader, word FIFO and wiper code latches of the quad wiper device.
// Assumes the link clock only toggles while chip select is low and that
// chip select stays high for at least three core clock cycles between words.
`timescale 1ns/1ps

module qwsl_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             flush_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);

	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PTR_W-1:0] wr_ptr_r;
	logic [PTR_W-1:0] rd_ptr_r;
	logic [CNT_W-1:0] count_r;
	logic             push;
	logic             pop;

	assign in_ready_o = (count_r != CNT_FULL);
	assign out_valid_o = (count_r != '0);
	assign out_data_o = mem_r[rd_ptr_r];
	assign push = in_valid_i & in_ready_o & ~flush_i;
	assign pop = out_valid_o & out_ready_i & ~flush_i;

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i || flush_i) begin
			wr_ptr_r <= '0;
		end else if (push) begin
			wr_ptr_r <= (wr_ptr_r == PTR_LAST) ? '0 : wr_ptr_r + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i || flush_i) begin
			rd_ptr_r <= '0;
		end else if (pop) begin
			rd_ptr_r <= (rd_ptr_r == PTR_LAST) ? '0 : rd_ptr_r + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i || flush_i) begin
			count_r <= '0;
		end else if (push && !pop) begin
			count_r <= count_r + 1'b1;
		end else if (pop && !push) begin
			count_r <= count_r - 1'b1;
		end
	end

endmodule

module qwsl_top
	import qwsl_pkg::*;
#(
	parameter int NUM_CHANNELS = CHANNELS,
	parameter int WORD_DEPTH   = FIFO_DEPTH
) (
	input  wire logic   core_clk_i,
	input  wire logic   rst_n_i,
	input  wire logic   link_sclk_i,
	input  wire logic   link_cs_n_i,
	input  wire logic   link_sdi_i,
	input  wire logic   preset_midscale_n_i,
	input  wire logic   power_down_n_i,
	input  wire logic   update_hold_i,
	output logic        link_sdo_o,
	output logic        link_sdo_oe_o,
	output logic        a_terminal_open_o,
	output logic        wiper_to_b_o,
	output logic        word_ready_o,
	output qwsl_code_t  wiper_code_latch_o [NUM_CHANNELS]
);

	// Link domain: the shift register runs on the serial clock itself.
	logic [WORD_BITS-1:0] shift_r;

	// Chip select gates the shift directly; it is the frame signal of this
	// clock, so the host timing makes it synchronous to the serial clock.
	always_ff @(posedge link_sclk_i) begin
		if (!link_cs_n_i) begin
			shift_r <= {shift_r[WORD_BITS-2:0], link_sdi_i};
		end
	end

	// Core domain: chip select, preset, power-down and the outgoing link bit pass two flip-flops.
	logic [SYNC_WIDTH-1:0] sync1_r;
	logic [SYNC_WIDTH-1:0] sync2_r;
	logic                  cs_s;
	logic                  preset_s;
	logic                  pdown_s;
	logic                  sdo_bit_s;

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			sync1_r <= {SYNC_WIDTH{1'b1}};
			sync2_r <= {SYNC_WIDTH{1'b1}};
		end else begin
			sync1_r <= {shift_r[WORD_BITS-1], power_down_n_i, preset_midscale_n_i, link_cs_n_i};
			sync2_r <= sync1_r;
		end
	end

	assign cs_s = sync2_r[SYNC_CS];
	assign preset_s = sync2_r[SYNC_PRESET];
	assign pdown_s = sync2_r[SYNC_PDOWN];
	assign sdo_bit_s = sync2_r[SYNC_SDO];

	logic cs_prev_r;
	logic cs_rise;

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			cs_prev_r <= 1'b1;
		end else begin
			cs_prev_r <= cs_s;
		end
	end

	assign cs_rise = cs_s & ~cs_prev_r;

	// The shift register is only sampled after chip select has been seen high
	// through the synchroniser, so it is quiet while the word is copied.
	qwsl_word_t in_word;
	qwsl_word_t out_word;
	logic       in_valid;
	logic       in_ready;
	logic       out_valid;
	logic       out_ready;

	assign in_word = qwsl_word_t'(shift_r);
	assign in_valid = cs_rise & preset_s;
	assign out_ready = ~update_hold_i & preset_s;

	qwsl_fifo #(
		.WIDTH (WORD_BITS),
		.DEPTH (WORD_DEPTH)
	) u_fifo (
		.clk_i       (core_clk_i),
		.rst_n_i     (rst_n_i),
		.flush_i     (~preset_s),
		.in_valid_i  (in_valid),
		.in_ready_o  (in_ready),
		.in_data_i   (in_word),
		.out_valid_o (out_valid),
		.out_ready_i (out_ready),
		.out_data_o  (out_word)
	);

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			word_ready_o <= 1'b0;
		end else begin
			word_ready_o <= in_ready & preset_s;
		end
	end

	// Loading carries on in power-down; only the terminals and the data-out enable change there.
	logic load;

	assign load = out_valid & out_ready;

	genvar ch;
	generate
		for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_latch
			always_ff @(posedge core_clk_i) begin
				if (!rst_n_i || !preset_s) begin
					wiper_code_latch_o[ch] <= CODE_MIDSCALE;
				end else if (load && int'(out_word.addr) == ch) begin
					wiper_code_latch_o[ch] <= out_word.code;
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			a_terminal_open_o <= 1'b0;
			wiper_to_b_o <= 1'b0;
		end else begin
			a_terminal_open_o <= ~pdown_s;
			wiper_to_b_o <= ~pdown_s;
		end
	end

	// The output only ever pulls low; a high level comes from the pull-up.
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			link_sdo_o <= 1'b0;
			link_sdo_oe_o <= 1'b0;
		end else begin
			link_sdo_o <= 1'b0;
			link_sdo_oe_o <= pdown_s & preset_s & ~cs_s & ~sdo_bit_s;
		end
	end

endmodule

//--- qwsl_asserts.sv
// Port checker for qwsl_top.
// Assumes one core clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
module qwsl_asserts
	import qwsl_pkg::*;
#(parameter int NUM_CHANNELS = 4) (
	input wire logic       core_clk_i,
	input wire logic       rst_n_i,
	input wire logic       preset_midscale_n_i,
	input wire logic       power_down_n_i,
	input wire logic       link_sdo_o,
	input wire logic       link_sdo_oe_o,
	input wire logic       a_terminal_open_o,
	input wire logic       wiper_to_b_o,
	input wire logic       word_ready_o,
	input wire qwsl_code_t wiper_code_latch_o [NUM_CHANNELS]
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Five cycles cover the two sync flops and the output register.
	chk_sdo_low: assert property (link_sdo_o == 1'b0) else $error("sdo high");
	chk_pd_release: assert property (!power_down_n_i [*5] |-> !link_sdo_oe_o) else $error("oe in pd");
	chk_pd_open: assert property (!power_down_n_i [*5] |-> a_terminal_open_o) else $error("a shut");
	chk_pd_exit: assert property (power_down_n_i [*5] |-> !a_terminal_open_o) else $error("a open");
	chk_wiper_b: assert property (wiper_to_b_o == a_terminal_open_o) else $error("wiper b");
	chk_preset_mid: assert property (!preset_midscale_n_i [*5] |->
		wiper_code_latch_o[0] == 8'h80 && wiper_code_latch_o[NUM_CHANNELS-1] == 8'h80) else $error("mid");
	chk_preset_oe: assert property (!preset_midscale_n_i [*5] |-> !link_sdo_oe_o) else $error("oe");
	chk_preset_gate: assert property (!preset_midscale_n_i [*5] |-> !word_ready_o) else $error("ready");
	cover property (!power_down_n_i [*5]);
	cover property (!preset_midscale_n_i [*5]);
	cover property (!word_ready_o && preset_midscale_n_i);
endmodule

//--- qwsl_host.sv
// Host model for the serial link of the loader.
// Assumes the bench hands in the pulled-up data-out pin level.
`timescale 1ns/1ps
module qwsl_host (
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      sdi_o,
	input  wire logic sdo_pin_i
);
	logic seen[$];
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		sdi_o = 1'b0;
	end
	// The link clock stands still between frames.
	task automatic send(input logic [19:0] v, input int n, input realtime hp);
		seen.delete();
		cs_n_o = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			sdi_o = v[i];
			#hp;
			seen.push_back(sdo_pin_i);
			sclk_o = 1'b1;
			#hp;
			sclk_o = 1'b0;
		end
		#hp;
		cs_n_o = 1'b1;
		sdi_o = ~sdi_o;
		#100;
	endtask
endmodule

//--- quad_wiper_serial_loader_tb_top.sv
// Testbench top for qwsl_top with the host model.
// Assumes the package, checker and host model are compiled first.
`timescale 1ns/1ps
`define CK(n, e, s) begin checked++; if ((s) !== (e)) begin num_errors++; $display("mismatch %s %h %h", n, e, s); end end
module quad_wiper_serial_loader_tb_top;
	import qwsl_pkg::*;
	logic        clk = 0, rst_n = 0, pre_n = 1, pd_n = 1, hold = 0;
	wire         sclk, cs_n, sdi, sdo, oe, aop, tob, rdy;
	qwsl_code_t  w [4];
	wire  [31:0] pk = {w[3], w[2], w[1], w[0]};
	logic [31:0] mdl = 32'h80808080, prv, e, q[$];
	int          num_errors = 0, checked = 0, cyc = 0;
	always #12.5 clk = ~clk;
	qwsl_host u_qwsl_host(.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_pin_i(!oe));
	qwsl_top u_qwsl_top(.core_clk_i(clk), .rst_n_i(rst_n), .link_sclk_i(sclk), .link_cs_n_i(cs_n),
		.link_sdi_i(sdi), .preset_midscale_n_i(pre_n), .power_down_n_i(pd_n), .update_hold_i(hold),
		.link_sdo_o(sdo), .link_sdo_oe_o(oe), .a_terminal_open_o(aop), .wiper_to_b_o(tob),
		.word_ready_o(rdy), .wiper_code_latch_o(w));
	task automatic tally_and_finish;
		$display("checked %0d num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// The note goes in before the frame, since the latch may change before send returns.
	task automatic wr(input logic [19:0] v, input int n, input realtime hp, input bit keep);
		logic [31:0] old;
		old = mdl;
		if (keep) mdl[v[9:8]*8 +: 8] = v[7:0];
		if (mdl !== old) q.push_back(mdl);
		u_qwsl_host.send(v, n, hp);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			tally_and_finish();
		end
		if (rst_n && pk !== prv) begin
			e = q.size() ? q.pop_front() : prv;
			`CK("codes", e, pk)
		end
		prv <= pk;
	end
	initial begin
		logic [19:0] v;
		v = 20'($urandom(32'hc297));
		repeat (12) @(posedge clk);
		rst_n <= 1;
		repeat (4) @(posedge clk);
		`CK("reset", 32'h80808080, pk)
		for (int i = 0; i < 12; i++)
			wr({10'($urandom), i[1:0], i < 4 ? 8'h00 : i < 8 ? 8'hff : 8'($urandom)}, 10 + i % 4, 7.5, 1);
		@(posedge clk) hold <= 1;
		for (int i = 0; i < 9; i++) wr(20'($urandom), 10, 7.5, i < 8);
		`CK("ready", 1'b0, rdy)
		@(posedge clk) hold <= 0;
		repeat (30) @(posedge clk) pd_n <= 0;
		repeat (5) @(posedge clk);
		`CK("open", 1'b1, aop)
		wr({10'h0, 2'd2, 8'h5a}, 10, 7.5, 1);
		@(posedge clk) pd_n <= 1;
		repeat (5) @(posedge clk);
		`CK("open", 1'b0, aop)
		if (mdl !== 32'h80808080) q.push_back(32'h80808080);
		mdl = 32'h80808080;
		@(posedge clk) pre_n <= 0;
		repeat (5) @(posedge clk);
		wr({10'h0, 2'd1, 8'h33}, 10, 7.5, 0);
		@(posedge clk) pre_n <= 1;
		repeat (6) @(posedge clk);
		`CK("mid", 32'h80808080, pk)
		wr(v, 20, 150, 1);
		for (int k = 10; k < 20; k++) `CK("sdo", v[29-k], u_qwsl_host.seen[k])
		repeat (20) @(posedge clk);
		`CK("left", 0, q.size())
		tally_and_finish();
	end
endmodule
bind qwsl_top qwsl_asserts #(.NUM_CHANNELS(NUM_CHANNELS)) u_qwsl_asserts(.core_clk_i(core_clk_i),
	.rst_n_i(rst_n_i), .preset_midscale_n_i(preset_midscale_n_i), .power_down_n_i(power_down_n_i),
	.link_sdo_o(link_sdo_o), .link_sdo_oe_o(link_sdo_oe_o), .a_terminal_open_o(a_terminal_open_o),
	.wiper_to_b_o(wiper_to_b_o), .word_ready_o(word_ready_o), .wiper_code_latch_o(wiper_code_latch_o));
